// [hdl/accessory_line_regs.vh]
// Register map, field positions and reset values of the accessory line port
`ifndef ACCESSORY_LINE_REGS_VH
`define ACCESSORY_LINE_REGS_VH

`define NUM_LINES 4
`define ADDR_W 8

`define OFS_LEVEL 8'h00
`define OFS_TOGGLE 8'h04
`define OFS_MODE 8'h08
`define OFS_STATUS 8'h0C

`define MODE_LINE0_RX_BIT 0
`define MODE_LINE1_SQL_BIT 1

`define STAT_LINE_LSB 0
`define STAT_SWITCH_LSB 4
`define STAT_RXTEST_BIT 8
`define STAT_SQUELCH_BIT 9
`define STAT_KEY_BIT 10

`define LEVEL_RST 4'h0
`define MODE_RST 2'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [hdl/pin_sync.v]
// Two-stage synchroniser for pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 5
) (
  input wire clock,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage is read by the second stage only
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule // pin_sync

// [hdl/accessory_logic_line_port.v]
// Accessory logic line port with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "accessory_line_regs.vh"

// Contract
// - Four lines, each with its own normal state that a press toggles.
// - Switch section closed: line driven as logic level from its setting.
// - Switch section open: line is a contact, opened or closed by setting.
// - Closed section and primary high: secondary pin also driven high.
// - Open section and line low: secondary pin left open circuit.
// - Only lines 0 and 1 have a function selector; others follow setting.
// - Selector in manual setting: line equals its normal-state value.
// - Line 0 in receive-test function: closed/high only in receiver test.
// - Key press moves receiver test to transmitter test; line 0 follows.
// - Line 1 in squelch function: closed/high while squelched, else open/low.
module accessory_logic_line_port #(
  parameter NLINES = `NUM_LINES
) (
  input wire clock,
  input wire nrst,
  // AXI4-Lite slave
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Instrument condition, same clock domain
  input wire rx_test_mode,
  input wire squelched,
  // Pins from outside
  input wire microphone_key_switch,
  input wire [NLINES-1:0] output_type_switch,
  // Accessory connector
  output wire [NLINES-1:0] line_out,
  output wire [NLINES-1:0] line_oe,
  output wire [NLINES-1:0] aux_out,
  output wire [NLINES-1:0] aux_oe,
  output wire [NLINES-1:0] contact_closed
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [NLINES:0] pins_sync;
  wire [NLINES-1:0] switch_closed;
  wire key_pressed;

  pin_sync #(
    .WIDTH(NLINES + 1)
  ) u_pin_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({microphone_key_switch, output_type_switch}),
    .sync_out(pins_sync)
  );

  assign switch_closed = pins_sync[NLINES-1:0];
  assign key_pressed = pins_sync[NLINES];

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  reg [NLINES-1:0] level_r;
  reg [1:0] mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  reg aw_held_r;
  reg [`ADDR_W-1:0] aw_addr_r;
  reg w_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  wire do_write;

  // Address and data taken in either order; no new ones while answering
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign do_write = aw_held_r & w_held_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // Byte lanes below a word are ignored, so aliases hit one register
  function [`ADDR_W-1:0] word_addr;
    input [`ADDR_W-1:0] addr;
    begin
      word_addr = {addr[`ADDR_W-1:2], 2'b00};
    end
  endfunction

  function mapped;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFS_LEVEL, `OFS_TOGGLE, `OFS_MODE, `OFS_STATUS: begin
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Address half; held until its data has arrived
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= {`ADDR_W{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= word_addr(s_axi_awaddr);
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Data half; held until its address has arrived
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Response one cycle after the pair is complete
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Settings; status is read-only and writes to it are dropped
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      level_r <= `LEVEL_RST;
      mode_r <= `MODE_RST;
    end else if (do_write && w_strb_r[0]) begin
      case (aw_addr_r)
        `OFS_LEVEL: begin
          level_r <= w_data_r[NLINES-1:0];
        end
        `OFS_TOGGLE: begin
          // Each set bit is one press of that line's control
          level_r <= level_r ^ w_data_r[NLINES-1:0];
        end
        `OFS_MODE: begin
          mode_r <= w_data_r[1:0];
        end
        default: begin
          level_r <= level_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line state
  reg [NLINES-1:0] state_nxt;
  wire in_rx_test;

  // Key press leaves receiver test for transmitter test
  assign in_rx_test = rx_test_mode & ~key_pressed;

  always @* begin
    state_nxt = level_r;
    if (mode_r[`MODE_LINE0_RX_BIT]) begin
      state_nxt[0] = in_rx_test;
    end
    if (mode_r[`MODE_LINE1_SQL_BIT]) begin
      state_nxt[1] = squelched;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive patterns
  wire [NLINES-1:0] logic_high;
  wire [NLINES-1:0] contact_shut;

  // A line is a driven level or a contact, never both
  assign logic_high = state_nxt & switch_closed;
  assign contact_shut = state_nxt & ~switch_closed;

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  reg [NLINES-1:0] state_r;
  reg [NLINES-1:0] line_out_r;
  reg [NLINES-1:0] line_oe_r;
  reg [NLINES-1:0] aux_out_r;
  reg [NLINES-1:0] aux_oe_r;
  reg [NLINES-1:0] contact_r;

  // Everything released or low on reset, so no accessory is keyed
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= {NLINES{1'b0}};
      line_out_r <= {NLINES{1'b0}};
      line_oe_r <= {NLINES{1'b0}};
      aux_out_r <= {NLINES{1'b0}};
      aux_oe_r <= {NLINES{1'b0}};
      contact_r <= {NLINES{1'b0}};
    end else begin
      state_r <= state_nxt;
      line_out_r <= logic_high;
      line_oe_r <= switch_closed;
      aux_out_r <= logic_high;
      // Secondary only driven when high in logic mode
      aux_oe_r <= logic_high;
      contact_r <= contact_shut;
    end
  end

  assign line_out = line_out_r;
  assign line_oe = line_oe_r;
  assign aux_out = aux_out_r;
  assign aux_oe = aux_oe_r;
  assign contact_closed = contact_r;

  ////////////////////////////////////////////////////////////////////////////
  // Status word; a live view, writes never reach it
  reg [31:0] status_word;

  always @* begin
    status_word = 32'h0000_0000;
    status_word[`STAT_LINE_LSB +: NLINES] = state_r;
    status_word[`STAT_SWITCH_LSB +: NLINES] = switch_closed;
    status_word[`STAT_RXTEST_BIT] = in_rx_test;
    status_word[`STAT_SQUELCH_BIT] = squelched;
    status_word[`STAT_KEY_BIT] = key_pressed;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] rd_nxt;
  wire [`ADDR_W-1:0] rd_addr;

  assign rd_addr = word_addr(s_axi_araddr);
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (rd_addr)
      `OFS_LEVEL: begin
        rd_nxt[NLINES-1:0] = level_r;
      end
      `OFS_MODE: begin
        rd_nxt[1:0] = mode_r;
      end
      `OFS_STATUS: begin
        rd_nxt = status_word;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_nxt;
      rresp_r <= mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // accessory_logic_line_port

// [tb/accessory_line_asserts.sv]
// Checker for the accessory line port pins and handshakes
`timescale 1ns/1ns
module accessory_line_asserts #(parameter NLINES = 4) (
  input wire clock,
  input wire nrst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire rx_test_mode,
  input wire squelched,
  input wire microphone_key_switch,
  input wire [NLINES-1:0] line_out,
  input wire [NLINES-1:0] line_oe,
  input wire [NLINES-1:0] aux_out,
  input wire [NLINES-1:0] aux_oe,
  input wire [NLINES-1:0] contact_closed
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Line state is the same in logic and contact mode
  wire [NLINES-1:0] state = line_out | contact_closed;
  //////////////////////////////////////////////////////////////////////////
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_write_answer;
    s_write_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no rvalid");
  property p_reset_low;
    $rose(nrst) |-> state == 0 && line_oe == 0 && aux_oe == 0;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("not idle");
  property p_aux_high;
    (line_oe & line_out & ~(aux_oe & aux_out)) == 0;
  endproperty
  a_aux_high: assert property (p_aux_high) else $error("aux low");
  property p_aux_follows;
    (aux_oe & ~(line_oe & line_out)) == 0;
  endproperty
  a_aux_follows: assert property (p_aux_follows)
    else $error("aux on");
  property p_contact_excl;
    (line_oe & contact_closed) == 0;
  endproperty
  a_contact_excl: assert property (p_contact_excl)
    else $error("both");
  property p_fixed_lines;
    $changed(state[NLINES-1:2]) |-> $past(s_axi_bvalid);
  endproperty
  a_fixed_lines: assert property (p_fixed_lines)
    else $error("line 2/3");
  property p_squelch_line;
    $changed(state[1]) |-> $past(s_axi_bvalid) ||
      $past(squelched) != $past(squelched, 2);
  endproperty
  a_squelch_line: assert property (p_squelch_line)
    else $error("line 1");
  property p_mode_line;
    $changed(state[0]) |-> $past(s_axi_bvalid) ||
      $past(rx_test_mode) != $past(rx_test_mode, 2) ||
      $past(microphone_key_switch, 3) != $past(microphone_key_switch, 4);
  endproperty
  a_mode_line: assert property (p_mode_line) else $error("line 0");
endmodule // accessory_line_asserts

// [tb/accessory_equipment.sv]
// Accessory equipment model sensing each line
`timescale 1ns/1ns
module accessory_equipment (
  input wire [3:0] line_out,
  input wire [3:0] line_oe,
  input wire [3:0] aux_out,
  input wire [3:0] aux_oe,
  input wire [3:0] contact_closed,
  output wire [3:0] engaged,
  output wire [3:0] aux_level
);
  // Released pins fall to the equipment pull-down
  assign aux_level = aux_oe & aux_out;
  assign engaged = (line_oe & line_out) | contact_closed;
endmodule // accessory_equipment

// [tb/accessory_logic_line_port_tb.sv]
// Testbench of the accessory line port
`timescale 1ns/1ns
`include "accessory_line_regs.vh"
module accessory_logic_line_port_tb;
  logic clock = 0;
  logic nrst = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic rx = 0, sq = 0, key = 0;
  logic [3:0] sw = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] lo, loe, ao, aoe, cc, engaged, aux_level;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  accessory_logic_line_port #(.NLINES(4)) dut (.clock(clock), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_test_mode(rx),
    .squelched(sq), .microphone_key_switch(key), .output_type_switch(sw),
    .line_out(lo), .line_oe(loe), .aux_out(ao), .aux_oe(aoe),
    .contact_closed(cc));
  accessory_equipment equipment (.line_out(lo), .line_oe(loe), .aux_out(ao),
    .aux_oe(aoe), .contact_closed(cc), .engaged(engaged),
    .aux_level(aux_level));
  initial forever #4 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Address and data released on their own handshakes
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    check(bresp, r);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    check({rresp, rdata}, {r, d});
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1;
    wt(1);
    check({aoe, loe, engaged}, 0);
    rd_reg(`OFS_LEVEL, 0, `RESP_OKAY);
    @(posedge clock);
    sw <= 4'hF;
    wr(`OFS_LEVEL, 32'h0000_0005, `RESP_OKAY);
    wt(5);
    check({loe, lo, aoe, aux_level, cc}, 20'hF_5550);
    wr(`OFS_TOGGLE, 32'h0000_000F, `RESP_OKAY);
    rd_reg(`OFS_LEVEL, 32'h0000_000A, `RESP_OKAY);
    @(posedge clock);
    sw <= 4'h0;
    wt(5);
    check({loe, aoe, cc, engaged, aux_level}, 20'h0_0AA0);
    wr(`OFS_LEVEL, 32'h0000_000F, `RESP_OKAY);
    wr(`OFS_MODE, 32'h0000_00FF, `RESP_OKAY);
    wt(2);
    check(cc, 4'hC);
    rd_reg(`OFS_MODE, 32'h0000_0003, `RESP_OKAY);
    @(posedge clock);
    rx <= 1;
    wt(2);
    check(cc, 4'hD);
    @(posedge clock);
    key <= 1;
    wt(5);
    check(cc, 4'hC);
    rd_reg(`OFS_STATUS, 32'h0000_000C | (32'h1 << `STAT_KEY_BIT),
      `RESP_OKAY);
    @(posedge clock);
    key <= 0;
    rx <= 0;
    sq <= 1;
    wt(5);
    check(cc, 4'hE);
    @(posedge clock);
    sq <= 0;
    wt(2);
    check(cc, 4'hC);
    @(posedge clock);
    rx <= 1;
    sq <= 1;
    wr(`OFS_MODE, 0, `RESP_OKAY);
    wr(`OFS_LEVEL, 32'h0000_0004, `RESP_OKAY);
    wt(3);
    check(cc, 4'h4);
    wr(8'h10, 32'h0000_0001, `RESP_SLVERR);
    rd_reg(8'h10, 0, `RESP_SLVERR);
    rd_reg(`OFS_LEVEL, 32'h0000_0004, `RESP_OKAY);
    @(posedge clock);
    nrst <= 0;
    wt(1);
    check({loe, aoe, engaged}, 0);
    @(posedge clock);
    nrst <= 1;
    wt(2);
    check({loe, aoe, engaged}, 0);
    rd_reg(`OFS_LEVEL, 0, `RESP_OKAY);
    complete_run;
  end
endmodule // accessory_logic_line_port_tb
bind accessory_logic_line_port accessory_line_asserts #(.NLINES(NLINES)) chk (
  .clock, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .rx_test_mode, .squelched, .microphone_key_switch,
  .line_out, .line_oe, .aux_out, .aux_oe, .contact_closed);
